// ==== hw/adc_ctrl_pkg.sv ====
// Purpose: shared constants and types for the serial converter control block
// Assumes: 100 MHz system clock; serial clock only runs inside frames
// Notes:   command byte fields, frame edge numbers, oscillator timing
package adc_ctrl_pkg;

    typedef logic [2:0] chan_t;

    // command byte layout and power-on value
    localparam int          CMD_CH_MSB   = 7;
    localparam int          CMD_CH_LSB   = 5;
    localparam int          CMD_SCAN_MSB = 4;
    localparam int          CMD_SCAN_LSB = 3;
    localparam int          CMD_PD_MSB   = 2;
    localparam int          CMD_PD_LSB   = 1;
    localparam int          CMD_CLK_BIT  = 0;
    localparam logic [7:0]  CMD_RESET    = 8'h06;

    typedef enum logic [1:0] {
        SCAN_SINGLE     = 2'b00,
        SCAN_FROM_ZERO  = 2'b01,
        SCAN_FROM_UPPER = 2'b10,
        SCAN_REPEAT     = 2'b11
    } scan_t;

    typedef enum logic [1:0] {
        PD_STAY_ON  = 2'b00,
        PD_FULL_OFF = 2'b01,
        PD_BUF_OFF  = 2'b10,
        PD_EXTERNAL = 2'b11
    } pd_t;

    typedef enum logic [1:0] {
        CV_IDLE  = 2'b00,
        CV_DELAY = 2'b01,
        CV_RUN   = 2'b10,
        CV_DONE  = 2'b11
    } conv_state_t;

    // serial frame edge numbers (1 = first edge after select)
    localparam logic [5:0]  EDGE_TRACK    = 6'd2;
    localparam logic [5:0]  EDGE_CHANNEL  = 6'd3;
    localparam logic [5:0]  EDGE_CMD_LAST = 6'd8;
    localparam logic [5:0]  EDGE_INT_OUT  = 6'd9;
    localparam logic [5:0]  EDGE_SAMPLE8  = 6'd6;
    localparam logic [5:0]  EDGE_FIRST8   = 6'd8;
    localparam logic [5:0]  EDGE_SAMPLE16 = 6'd14;
    localparam logic [5:0]  EDGE_FIRST16  = 6'd16;
    localparam logic [5:0]  RESULT_SPAN   = 6'd14;
    localparam logic [5:0]  COUNT_MAX     = 6'h3f;

    // result layout
    localparam int          RESULT_BITS = 14;
    localparam int          SCAN_DEPTH  = 8;
    localparam logic [3:0]  TOP_BIT     = 4'd13;
    localparam logic [2:0]  UPPER_START = 3'd4;
    localparam logic [2:0]  LAST_SLOT   = 3'd7;

    // oscillator start delay, least time so rounded up
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          OSC_START_NS  = 125;
    localparam int          OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0]  OSC_START_END = 5'(OSC_START_CYC - 1);

    // internal oscillator divider end in system clocks (period is 4) and its cycle numbers
    localparam logic [1:0]  OSC_DIV_END   = 2'd3;
    localparam logic [4:0]  INT_ACQ_START = 5'd2;
    localparam logic [4:0]  INT_ACQ_END   = 5'd7;
    localparam logic [4:0]  INT_BIT_FIRST = 5'd7;
    localparam logic [4:0]  INT_BIT_LAST  = 5'd20;
    localparam logic [4:0]  INT_CONV_CYC  = 5'd25;

endpackage

// ==== hw/adc_serial_conversion_control.sv ====
// Purpose: digital control of a multichannel serial converter: command intake,
//          external and internal clock conversion timing, scan, power-down
// Assumes: host keeps word_width_sel static in a frame; frame_sync_in low at select picks frame-sync mode, its fall in the frame wakes
// Notes:   serial clock frame logic, but not the command, is cleared asynchronously while chip_select_n is high
`timescale 1ns/1ns
module adc_serial_conversion_control (
    // system
    input  wire  logic                 clk,
    input  wire  logic                 sys_rst,
    // serial link
    input  wire  logic                 serial_clk,
    input  wire  logic                 chip_select_n,
    input  wire  logic                 serial_in,
    output logic                       serial_out,
    output logic                       serial_out_en,
    output logic                       conv_done_n,
    input  wire  logic                 frame_sync_in,
    input  wire  logic                 word_width_sel,
    // analog front end
    input  wire  logic                 sar_decision,
    output adc_ctrl_pkg::chan_t        mux_channel,
    output logic                       track_ext,
    output logic                       convert_ext,
    output adc_ctrl_pkg::chan_t        scan_channel,
    output logic                       track_int,
    output logic                       osc_enable,
    output logic                       ref_on,
    output logic                       buf_on
);
    import adc_ctrl_pkg::*;

    // rising serial edge state, cleared per frame
    typedef struct packed {
        logic [5:0] count;
        logic [7:0] shift;
        chan_t      chan;
        logic       cmdDone;
        logic       wsMeta;
        logic       wsSync;
    } frame_t;

    // command survives across frames, so only system reset clears it
    typedef struct packed {
        logic [7:0] value;
    } cmd_t;

    // falling serial edge state, cleared per frame
    typedef struct packed {
        logic       dout;
        logic       useFirst;
        logic       track;
        logic       conv;
        logic [6:0] outIdx;
    } fall_t;

    typedef struct packed {
        logic                                  csMeta;
        logic                                  csSync;
        logic                                  csPrev;
        logic                                  fsMeta;
        logic                                  fsSync;
        logic                                  fsPrev;
        logic                                  doneMeta;
        logic                                  doneSync;
        logic                                  donePrev;
        logic                                  dspMode;
        pd_t                                   pdMode;
        logic                                  refOn;
        logic                                  bufOn;
        conv_state_t                           state;
        logic [4:0]                            timer;
        logic [1:0]                            divCnt;
        logic [4:0]                            intCycle;
        logic [2:0]                            convIdx;
        chan_t                                 scanCh;
        logic [3:0]                            resultCount;
        logic                                  track;
        logic                                  osc;
        logic                                  convDoneN;
        logic                                  firstBit;
        logic [SCAN_DEPTH-1:0][RESULT_BITS-1:0] mem;
    } core_t;

    frame_t fr;
    frame_t next_fr;
    cmd_t   cm;
    cmd_t   next_cm;
    fall_t  fl;
    fall_t  next_fl;
    core_t  cr;
    core_t  next_cr;
    logic   linkRst;

    // frame logic must be idle whenever the host deselects
    assign linkRst = sys_rst | chip_select_n;

    // ---------------- serial clock, rising edges ----------------
    always_comb begin
        next_fr = fr;
        next_cm = cm;
        next_fr.wsMeta = word_width_sel;
        next_fr.wsSync = fr.wsMeta;
        if (fr.count != COUNT_MAX) begin
            next_fr.count = fr.count + 6'd1;
        end
        if (fr.count < EDGE_CMD_LAST) begin
            next_fr.shift = {fr.shift[6:0], serial_in};
        end
        if (fr.count == EDGE_CHANNEL - 6'd1) begin
            next_fr.chan = {fr.shift[1:0], serial_in};
        end
        if (fr.count == EDGE_CMD_LAST - 6'd1) begin
            next_fr.cmdDone = 1'b1;
            next_cm.value   = {fr.shift[6:0], serial_in};
        end
    end

    always_ff @(posedge serial_clk or posedge linkRst) begin
        if (linkRst) begin
            fr <= '0;
        end else begin
            fr <= next_fr;
        end
    end

    always_ff @(posedge serial_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cm <= '{value: CMD_RESET};
        end else begin
            cm <= next_cm;
        end
    end

    // ---------------- serial clock, falling edges ----------------
    logic       intMode;
    logic [5:0] edgeFirst;
    logic [5:0] edgeSample;
    logic [3:0] streamPos;
    logic       streamBit;
    logic [6:0] idxInc;

    assign intMode    = cm.value[CMD_CLK_BIT];
    assign edgeFirst  = fr.wsSync ? EDGE_FIRST16 : EDGE_FIRST8;
    assign edgeSample = fr.wsSync ? EDGE_SAMPLE16 : EDGE_SAMPLE8;
    assign streamPos  = fl.outIdx[3:0];
    // results are quiet once done is low, so reading them here is safe
    assign streamBit  = (streamPos <= TOP_BIT) ?
                        cr.mem[fl.outIdx[6:4]][TOP_BIT - streamPos] : 1'b0;
    assign idxInc     = fl.outIdx + 7'd1;

    always_comb begin
        next_fl = fl;
        if (fr.count == EDGE_TRACK) begin
            next_fl.track = 1'b1;
        end
        if (fr.count == edgeSample) begin
            next_fl.track = 1'b0;
            next_fl.conv  = 1'b1;
        end
        // mode bit is the last command bit, so an internal frame drops this late
        if (fr.count == edgeFirst + RESULT_SPAN - 6'd1 ||
            (intMode && fr.count >= EDGE_CMD_LAST)) begin
            next_fl.conv = 1'b0;
        end
        if (intMode) begin
            if (fr.count >= EDGE_INT_OUT) begin
                next_fl.useFirst = 1'b0;
                next_fl.dout     = streamBit;
                if ({1'b0, idxInc} == {cr.resultCount, 4'h0}) begin
                    next_fl.outIdx = 7'd0;
                end else begin
                    next_fl.outIdx = idxInc;
                end
            end else begin
                next_fl.dout = 1'b0;
            end
        end else begin
            if (fr.count >= edgeFirst) begin
                next_fl.useFirst = 1'b0;
            end
            if (fr.count >= edgeFirst && fr.count < edgeFirst + RESULT_SPAN) begin
                next_fl.dout = sar_decision;
            end else begin
                next_fl.dout = 1'b0;
            end
        end
    end

    always_ff @(negedge serial_clk or posedge linkRst) begin
        if (linkRst) begin
            fl <= '{dout: 1'b0, useFirst: 1'b1, track: 1'b0, conv: 1'b0, outIdx: 7'd1};
        end else begin
            fl <= next_fl;
        end
    end

    // ---------------- system clock: power and internal conversion ----------------
    logic        csRise;
    logic        csFall;
    logic        fsFall;
    logic        doneRise;
    logic        wake;
    logic        tick;
    logic [4:0]  cyc;
    logic        lastConv;
    scan_t       scanSel;
    chan_t       topCh;
    chan_t       startCh;

    assign csRise   = cr.csSync & ~cr.csPrev;
    assign csFall   = ~cr.csSync & cr.csPrev;
    assign fsFall   = ~cr.fsSync & cr.fsPrev;
    assign doneRise = cr.doneSync & ~cr.donePrev;
    assign wake     = (csFall & cr.fsSync) | (cr.dspMode & fsFall & ~cr.csSync);
    assign tick     = (cr.divCnt == OSC_DIV_END);
    assign cyc      = cr.intCycle + 5'd1;
    assign scanSel  = scan_t'(cm.value[CMD_SCAN_MSB:CMD_SCAN_LSB]);
    assign topCh    = cm.value[CMD_CH_MSB:CMD_CH_LSB];

    always_comb begin
        unique case (scanSel)
            SCAN_SINGLE:     startCh = topCh;
            SCAN_FROM_ZERO:  startCh = 3'h0;
            SCAN_FROM_UPPER: startCh = (topCh >= UPPER_START) ? UPPER_START : topCh;
            SCAN_REPEAT:     startCh = topCh;
        endcase
        unique case (scanSel)
            SCAN_SINGLE:     lastConv = 1'b1;
            SCAN_FROM_ZERO:  lastConv = (cr.scanCh == topCh);
            SCAN_FROM_UPPER: lastConv = (cr.scanCh == topCh);
            SCAN_REPEAT:     lastConv = (cr.convIdx == LAST_SLOT);
        endcase
    end

    always_comb begin
        next_cr = cr;
        next_cr.csMeta   = chip_select_n;
        next_cr.csSync   = cr.csMeta;
        next_cr.csPrev   = cr.csSync;
        next_cr.fsMeta   = frame_sync_in;
        next_cr.fsSync   = cr.fsMeta;
        next_cr.fsPrev   = cr.fsSync;
        next_cr.doneMeta = fr.cmdDone;
        next_cr.doneSync = cr.doneMeta;
        next_cr.donePrev = cr.doneSync;

        if (csFall) begin
            next_cr.dspMode = ~cr.fsSync;
        end
        if (wake && cr.pdMode != PD_EXTERNAL) begin
            next_cr.refOn = 1'b1;
            next_cr.bufOn = 1'b1;
        end
        if (csRise) begin
            next_cr.pdMode = pd_t'(cm.value[CMD_PD_MSB:CMD_PD_LSB]);
            unique case (pd_t'(cm.value[CMD_PD_MSB:CMD_PD_LSB]))
                PD_STAY_ON: begin
                    next_cr.refOn = 1'b1;
                    next_cr.bufOn = 1'b1;
                end
                PD_FULL_OFF: begin
                    next_cr.refOn = 1'b0;
                    next_cr.bufOn = 1'b0;
                end
                PD_BUF_OFF: begin
                    next_cr.refOn = 1'b1;
                    next_cr.bufOn = 1'b0;
                end
                PD_EXTERNAL: begin
                    next_cr.refOn = 1'b0;
                    next_cr.bufOn = 1'b0;
                end
            endcase
        end

        if (cr.csSync) begin
            // deselect ends any conversion at once
            next_cr.state     = CV_IDLE;
            next_cr.osc       = 1'b0;
            next_cr.track     = 1'b0;
            next_cr.convDoneN = 1'b1;
            next_cr.firstBit  = 1'b0;
        end else begin
            unique case (cr.state)
                CV_IDLE: begin
                    if (doneRise && cm.value[CMD_CLK_BIT]) begin
                        next_cr.state = CV_DELAY;
                        next_cr.timer = 5'd0;
                    end
                end
                CV_DELAY: begin
                    next_cr.timer = cr.timer + 5'd1;
                    if (cr.timer == OSC_START_END) begin
                        next_cr.state       = CV_RUN;
                        next_cr.osc         = 1'b1;
                        next_cr.divCnt      = 2'd0;
                        next_cr.intCycle    = 5'd0;
                        next_cr.convIdx     = 3'd0;
                        next_cr.scanCh      = startCh;
                        next_cr.resultCount = 4'd0;
                    end
                end
                CV_RUN: begin
                    next_cr.divCnt = cr.divCnt + 2'd1;
                    if (tick) begin
                        next_cr.divCnt   = 2'd0;
                        next_cr.intCycle = cyc;
                        if (cyc == INT_ACQ_START) begin
                            next_cr.track = 1'b1;
                        end
                        if (cyc == INT_ACQ_END) begin
                            next_cr.track = 1'b0;
                        end
                        if (cyc >= INT_BIT_FIRST && cyc <= INT_BIT_LAST) begin
                            next_cr.mem[cr.convIdx][4'(INT_BIT_LAST - cyc)] = sar_decision;
                        end
                        if (cyc == INT_CONV_CYC) begin
                            next_cr.resultCount = {1'b0, cr.convIdx} + 4'd1;
                            next_cr.intCycle    = 5'd0;
                            if (lastConv) begin
                                // results only leave after the whole sequence
                                next_cr.state     = CV_DONE;
                                next_cr.osc       = 1'b0;
                                next_cr.convDoneN = 1'b0;
                                next_cr.firstBit  = cr.mem[0][RESULT_BITS-1];
                            end else begin
                                next_cr.convIdx = cr.convIdx + 3'd1;
                                next_cr.scanCh  = (scanSel == SCAN_REPEAT) ?
                                                  cr.scanCh : cr.scanCh + 3'd1;
                            end
                        end
                    end
                end
                CV_DONE: begin
                    next_cr.state = CV_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cr           <= '0;
            cr.csMeta    <= 1'b1;
            cr.csSync    <= 1'b1;
            cr.csPrev    <= 1'b1;
            cr.fsMeta    <= 1'b1;
            cr.fsSync    <= 1'b1;
            cr.fsPrev    <= 1'b1;
            cr.pdMode    <= PD_EXTERNAL;
            cr.state     <= CV_IDLE;
            cr.convDoneN <= 1'b1;
        end else begin
            cr <= next_cr;
        end
    end

    // ---------------- outputs ----------------
    // before the first internal read edge the MSB must show with no serial edge
    assign serial_out    = fl.useFirst ? cr.firstBit : fl.dout;
    assign serial_out_en = ~chip_select_n;
    assign conv_done_n   = cr.convDoneN;
    assign mux_channel   = fr.chan;
    assign track_ext     = fl.track;
    assign convert_ext   = fl.conv;
    assign scan_channel  = cr.scanCh;
    assign track_int     = cr.track;
    assign osc_enable    = cr.osc;
    assign ref_on        = cr.refOn;
    assign buf_on        = cr.bufOn;

endmodule

// ==== bench/adc_ctrl_sva.sv ====
// Purpose: port-level timing checks for the converter control block
// Assumes: serial clock stands still outside frames
// Notes:   bound to the design top after the module
`timescale 1ns/1ns
module adc_ctrl_sva (
    // clocks and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic serial_clk,
    // link and front end
    input wire logic chip_select_n,
    input wire logic word_width_sel,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic conv_done_n,
    input wire logic track_ext,
    input wire logic convert_ext,
    input wire logic track_int,
    input wire logic osc_enable,
    input wire logic ref_on,
    input wire logic buf_on
);
    property p_en;
        @(posedge clk) disable iff (sys_rst) serial_out_en == !chip_select_n;
    endproperty
    a_en: assert property (p_en) else $error("enable differs from select");
    property p_selLow;
        @(posedge clk) disable iff (sys_rst) $fell(chip_select_n) |-> !serial_out;
    endproperty
    a_selLow: assert property (p_selLow) else $error("output not low at select");
    property p_bufRef;
        @(posedge clk) disable iff (sys_rst) buf_on |-> ref_on;
    endproperty
    a_bufRef: assert property (p_bufRef) else $error("buffer on without reference");
    // power may not move once chip_select_n has been high for five clocks
    property p_pdHold;
        @(posedge clk) disable iff (sys_rst)
            chip_select_n && $past(chip_select_n, 5) |-> $stable(ref_on) && $stable(buf_on);
    endproperty
    a_pdHold: assert property (p_pdHold) else $error("power moved while idle");
    property p_doneOsc;
        @(posedge clk) disable iff (sys_rst) $fell(conv_done_n) |-> $fell(osc_enable);
    endproperty
    a_doneOsc: assert property (p_doneOsc) else $error("oscillator runs past done");
    property p_abortInt;
        @(posedge clk) disable iff (sys_rst)
            chip_select_n [*5] |-> !osc_enable && conv_done_n && !track_int;
    endproperty
    a_abortInt: assert property (p_abortInt) else $error("internal work while idle");
    property p_abortExt;
        @(posedge clk) disable iff (sys_rst) $rose(chip_select_n) |-> !convert_ext && !track_ext;
    endproperty
    a_abortExt: assert property (p_abortExt) else $error("link conversion not aborted");
    property p_trackInt;
        // a deselect may legally cut an acquire short
        @(posedge clk) disable iff (sys_rst || chip_select_n)
            $rose(track_int) |-> ##19 track_int ##1 !track_int;
    endproperty
    a_trackInt: assert property (p_trackInt) else $error("internal acquire length");
    property p_trackExt8;
        @(negedge serial_clk) disable iff (sys_rst) $rose(track_ext) && !word_width_sel
            |-> track_ext [*4] ##1 (!track_ext && convert_ext);
    endproperty
    a_trackExt8: assert property (p_trackExt8) else $error("8-bit sample edge");
    property p_trackExt16;
        @(negedge serial_clk) disable iff (sys_rst) $rose(track_ext) && word_width_sel
            |-> ##11 track_ext ##1 (!track_ext && convert_ext);
    endproperty
    a_trackExt16: assert property (p_trackExt16) else $error("16-bit sample edge");
endmodule
bind adc_serial_conversion_control adc_ctrl_sva adc_ctrl_sva_i (
    .clk, .sys_rst, .serial_clk, .chip_select_n, .word_width_sel, .serial_out,
    .serial_out_en, .conv_done_n, .track_ext, .convert_ext, .track_int,
    .osc_enable, .ref_on, .buf_on
);

// ==== bench/spi_host_model.sv ====
// Purpose: serial host driving frames, mode 0, 32 ns serial clock
// Assumes: tasks are called from one process at a time
// Notes:   rx keeps the last 32 bits sampled on rising edges
`timescale 1ns/1ns
module spi_host_model (
    // link outputs
    output logic      serial_clk,
    output logic      chip_select_n,
    output logic      serial_in,
    // link inputs
    input  wire logic serial_out,
    input  wire logic conv_done_n
);
    logic        lk = 1'b0;
    logic        gate = 1'b0;
    logic [31:0] rx = '0;
    // gated so the serial clock stands still between frames
    assign serial_clk = lk & gate;
    initial begin
        chip_select_n = 1'b1;
        serial_in = 1'b0;
        #3;
        forever #16 lk = ~lk;
    end
    task automatic sel();
        @(negedge lk);
        chip_select_n = 1'b0;
        // settle wait scaled far down; only the power logic is modelled
        repeat (3) @(negedge lk);
    endtask
    task automatic desel();
        @(negedge lk);
        chip_select_n = 1'b1;
        serial_in = ~serial_in;
        repeat (3) @(negedge lk);
    endtask
    task automatic clocks(input logic [7:0] cmd, input int n, input bit holdForDone);
        for (int i = 0; i < n; i++) begin
            serial_in = (i < 8) ? cmd[7 - i] : ~serial_in;
            gate = 1'b1;
            @(posedge lk);
            rx = {rx[30:0], serial_out};
            @(negedge lk);
            if (i == 7 && holdForDone) begin
                gate = 1'b0;
                for (int k = 0; k < 3000 && conv_done_n !== 1'b0; k++) @(negedge lk);
            end
        end
        // stop after each burst so no stray edge reaches the device
        gate = 1'b0;
    endtask
endmodule

// ==== bench/test_adc_serial_conversion_control.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: comparator bit follows rise parity in external mode, 1 in internal
// Notes:   link traffic comes from the host model
`timescale 1ns/1ns
module test_adc_serial_conversion_control;
    import adc_ctrl_pkg::*;
    logic  clk = 1'b0;
    logic  sys_rst = 1'b1;
    logic  frame_sync_in = 1'b1;
    logic  word_width_sel = 1'b0;
    logic  sar_decision = 1'b0;
    logic  intMode = 1'b0;
    wire   serial_clk, chip_select_n, serial_in, serial_out, serial_out_en, conv_done_n;
    chan_t mux_channel, scan_channel, chAt3, chAt4;
    logic  track_ext, convert_ext, track_int, osc_enable, ref_on, buf_on;
    int    mismatches = 0;
    int    num_checks = 0;
    int    riseCnt = 0;
    int    cycles = 0;
    time   t8, oscT, doneT;
    chan_t seenCh[$];
    always #5 clk = ~clk;
    adc_serial_conversion_control adc_serial_conversion_control_i (
        .clk, .sys_rst, .serial_clk, .chip_select_n, .serial_in, .serial_out,
        .serial_out_en, .conv_done_n, .frame_sync_in, .word_width_sel, .sar_decision,
        .mux_channel, .track_ext, .convert_ext, .scan_channel, .track_int,
        .osc_enable, .ref_on, .buf_on
    );
    spi_host_model host_i (.serial_clk, .chip_select_n, .serial_in, .serial_out, .conv_done_n);
    always @(posedge serial_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            riseCnt <= 0;
        end else begin
            riseCnt <= riseCnt + 1;
            if (riseCnt == 2) chAt3 <= mux_channel;
            if (riseCnt == 3) chAt4 <= mux_channel;
            if (riseCnt == 7) t8 <= $time;
        end
    end
    always @(posedge clk) begin
        sar_decision <= intMode | riseCnt[0];
        cycles <= cycles + 1;
        if ($rose(osc_enable)) oscT <= $time;
        if ($fell(conv_done_n)) doneT <= $time;
        if ($rose(track_int)) seenCh.push_back(scan_channel);
        if (cycles == 40000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic t_pd();
        logic [1:0] pd;
        for (int i = 0; i < 4; i++) begin
            pd = 2'(i);
            host_i.sel();
            host_i.clocks({5'h00, pd, 1'b0}, 24, 1'b0);
            if (i > 0) check("power before release", 2'b11, {ref_on, buf_on});
            host_i.desel();
            check("power idle", {~pd[0], pd == 2'b00}, {ref_on, buf_on});
            host_i.sel();
            check("power awake", (pd == 2'b11) ? 2'b00 : 2'b11, {ref_on, buf_on});
            host_i.desel();
        end
        host_i.sel();
        host_i.clocks(8'h02, 24, 1'b0);
        host_i.desel();
        @(posedge clk);
        frame_sync_in <= 1'b0;
        repeat (4) @(posedge clk);
        host_i.sel();
        check("no wake in frame-sync mode", 2'b00, {ref_on, buf_on});
        frame_sync_in <= 1'b1;
        repeat (4) @(posedge clk);
        frame_sync_in <= 1'b0;
        repeat (6) @(posedge clk);
        check("wake on frame sync fall", 2'b11, {ref_on, buf_on});
        host_i.desel();
        @(posedge clk);
        frame_sync_in <= 1'b1;
    endtask
    task automatic t_ext(input logic wide, input chan_t ch);
        @(posedge clk);
        word_width_sel <= wide;
        intMode <= 1'b0;
        seenCh = {};
        host_i.sel();
        // scan bits set on purpose: external mode must ignore them
        host_i.clocks({ch, 2'b01, 2'b00, 1'b0}, wide ? 36 : 28, 1'b0);
        check("mux before rise 3", 3'd0, chAt3);
        check("mux after rise 3", ch, chAt4);
        check("result then zeros", {14'h1555, 6'h00}, host_i.rx[19:0]);
        host_i.desel();
        check("done stays high", 1'b1, conv_done_n);
        check("no internal conversions", 0, seenCh.size());
    endtask
    task automatic t_abort();
        // earlier scenario leaves 16-bit framing selected
        @(posedge clk);
        word_width_sel <= 1'b0;
        host_i.sel();
        host_i.clocks(8'h20, 12, 1'b0);
        check("converting mid frame", 1'b1, convert_ext);
        host_i.desel();
        check("convert after abort", 1'b0, convert_ext);
        @(posedge clk);
        intMode <= 1'b1;
        host_i.sel();
        host_i.clocks(8'h21, 8, 1'b0);
        for (int k = 0; k < 100 && osc_enable !== 1'b1; k++) @(posedge clk);
        repeat (30) @(posedge clk);
        host_i.desel();
        check("oscillator and done after abort", 2'b01, {osc_enable, conv_done_n});
    endtask
    task automatic t_scan(input logic [1:0] code);
        chan_t expq[$];
        expq = {};
        for (int c = 0; c < 8; c++) begin
            if (code == 2'b11 || (code == 2'b00 ? c == 5 : c <= 5 && (code == 2'b01 || c >= 4)))
                expq.push_back((code == 2'b11) ? 3'd5 : 3'(c));
        end
        @(posedge clk);
        intMode <= 1'b1;
        seenCh = {};
        host_i.sel();
        host_i.clocks({3'd5, code, 2'b00, 1'b1}, 40, 1'b1);
        check("oscillator start delay", 1'b1, oscT - t8 >= 125 && oscT - t8 <= 200);
        check("conversion time", 1'b1, doneT - oscT + 40 >= expq.size() * 1000
              && doneT - oscT <= expq.size() * 1000 + 40);
        check("scan count", expq.size(), seenCh.size());
        foreach (expq[j]) if (j < seenCh.size()) check("scan order", expq[j], seenCh[j]);
        check("result repeats", {2{14'h3fff, 2'b00}}, host_i.rx);
        host_i.desel();
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        check("state in reset", 3'b001, {ref_on, buf_on, conv_done_n});
        t_pd();
        t_ext(1'b0, 3'd6);
        t_ext(1'b1, 3'd3);
        t_abort();
        for (int s = 0; s < 4; s++) t_scan(2'(s));
        report_and_stop();
    end
endmodule
